// ===== hdl/tcid_defines.svh
`ifndef TCID_DEFINES_SVH
`define TCID_DEFINES_SVH

// byte offsets of the capability words
`define TCID_OFF_FOUR 12'h1F0
`define TCID_OFF_FIVE 12'h1F4

// first capability word field values
`define TCID_VM_CTX_CNT 4'h1
`define TCID_CTX_CNT 4'h1
`define TCID_SSHOT_CNT 4'h1
`define TCID_RSEL_PAIR_CNT 4'h7
`define TCID_PE_CMP_CNT 4'h0
`define TCID_DADDR_SUPP 1'h0
`define TCID_DVAL_CNT 4'h0
`define TCID_ADDR_PAIR_CNT 4'h4

// second capability word field values
`define TCID_COUNTER_CNT 3'h2
`define TCID_SEQ_STATE_CNT 3'h4
`define TCID_LP_OVR_SUPP 1'h0
`define TCID_BUS_TRIG_SUPP 1'h1
`define TCID_ID_WIDTH 6'h07
`define TCID_EXT_SEL_CNT 3'h4
`define TCID_EXT_IN_CNT 9'h1FF

// read data outside the read answer cycle
`define TCID_RD_IDLE 32'h0000_0000

`endif

// ===== hdl/tcid_pkg.sv
package tcid_pkg;

  typedef struct packed {
    logic [3:0] vm_context_comparator_count;
    logic [3:0] context_comparator_count;
    logic [3:0] single_shot_control_count;
    logic [3:0] resource_selector_pair_count;
    logic [3:0] pe_comparator_input_count;
    logic [2:0] rsvd_11_9;
    logic data_address_compare_support;
    logic [3:0] data_value_comparator_count;
    logic [3:0] address_comparator_pair_count;
  } tcid_four_t;

  typedef struct packed {
    logic rsvd_31;
    logic [2:0] trace_counter_count;
    logic [2:0] sequencer_state_count;
    logic rsvd_24;
    logic low_power_override_support;
    logic trace_bus_trigger_support;
    logic [5:0] trace_id_width;
    logic [3:0] rsvd_15_12;
    logic [2:0] external_input_selector_count;
    logic [8:0] external_input_count;
  } tcid_five_t;

endpackage

// ===== hdl/tcid_regs.sv
`timescale 1ns/100ps
`include "tcid_defines.svh"

// Functional notes
// R1: one virtual context comparator in [31:28]
// R2: one context comparator in [27:24]
// R3: one single-shot control in [23:20]
// R4: eight resource selector pairs, code 0111
// R5: no PE comparator inputs, zero
// R6: data address compare unsupported, zero
// R7: no data value comparators, zero
// R8: four address comparator pairs, code 0100
// R9: two counters in second word
// R10: sequencer present, four states
// R11: low-power override unsupported, zero
// R12: trace bus triggers supported, one
// R13: trace identifier width seven bits
// R14: four external input selectors
// R15: external inputs field all ones
// R16: read-only constants, reserved zero, writes ignored
module tcid_regs #(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [31:0] reg_rd_data_ff,
  output logic reg_rd_hit_ff
);

  generate
    if (ADDR_W < 9 || ADDR_W > 32)
    begin : g_bad_addr_w
      $error("tcid_regs: ADDR_W must lie in 9..32");
    end
  endgenerate

  tcid_pkg::tcid_four_t cap_four;
  tcid_pkg::tcid_five_t cap_five;
  logic sel_four;
  logic sel_five;
  logic [31:0] nxt_reg_rd_data;
  logic nxt_reg_rd_hit;

  // fixed capability words, built from constants only
  always_comb
  begin
    cap_four = '0;
    cap_four.vm_context_comparator_count = `TCID_VM_CTX_CNT; // R1
    cap_four.context_comparator_count = `TCID_CTX_CNT; // R2
    cap_four.single_shot_control_count = `TCID_SSHOT_CNT; // R3
    cap_four.resource_selector_pair_count = `TCID_RSEL_PAIR_CNT; // R4
    cap_four.pe_comparator_input_count = `TCID_PE_CMP_CNT; // R5
    cap_four.data_address_compare_support = `TCID_DADDR_SUPP; // R6
    cap_four.data_value_comparator_count = `TCID_DVAL_CNT; // R7
    cap_four.address_comparator_pair_count = `TCID_ADDR_PAIR_CNT; // R8
  end

  always_comb
  begin
    cap_five = '0;
    cap_five.trace_counter_count = `TCID_COUNTER_CNT; // R9
    cap_five.sequencer_state_count = `TCID_SEQ_STATE_CNT; // R10
    cap_five.low_power_override_support = `TCID_LP_OVR_SUPP; // R11
    cap_five.trace_bus_trigger_support = `TCID_BUS_TRIG_SUPP; // R12
    cap_five.trace_id_width = `TCID_ID_WIDTH; // R13
    cap_five.external_input_selector_count = `TCID_EXT_SEL_CNT; // R14
    cap_five.external_input_count = `TCID_EXT_IN_CNT; // R15
  end

  assign sel_four = reg_addr == ADDR_W'(`TCID_OFF_FOUR);
  assign sel_five = reg_addr == ADDR_W'(`TCID_OFF_FIVE);

  // write strobe and write data are deliberately unused: no storage exists
  always_comb
  begin
    nxt_reg_rd_data = `TCID_RD_IDLE;
    nxt_reg_rd_hit = 1'b0;
    if (reg_rd_en)
    begin
      if (sel_four)
      begin
        nxt_reg_rd_data = cap_four; // R16
        nxt_reg_rd_hit = 1'b1;
      end
      else if (sel_five)
      begin
        nxt_reg_rd_data = cap_five; // R16
        nxt_reg_rd_hit = 1'b1;
      end
    end
  end

  // data held only in the answer cycle so stale words never look valid
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rd_data_ff <= `TCID_RD_IDLE;
    end
    else
    begin
      reg_rd_data_ff <= nxt_reg_rd_data;
    end
  end

  // hit flag kept apart so a decode change never touches the data path
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rd_hit_ff <= 1'b0;
    end
    else
    begin
      reg_rd_hit_ff <= nxt_reg_rd_hit;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence rd_four_s;
    reg_rd_en && sel_four;
  endsequence

  sequence rd_five_s;
    reg_rd_en && sel_five;
  endsequence

  // one checker per reserved bit so a failing position is easy to spot
  localparam logic [31:0] RSVD_FOUR_MASK = 32'h0000_0E00;
  localparam logic [31:0] RSVD_FIVE_MASK = 32'h8100_F000;

  generate
    for (genvar b = 0; b < 32; b++)
    begin : g_rsvd_bit
      if (RSVD_FOUR_MASK[b])
      begin : g_four
        a_rsvd_four_bit: assert property (rd_four_s |=> !reg_rd_data_ff[b]) // R16
          else $error("reserved bit set in first capability word");
      end
      if (RSVD_FIVE_MASK[b])
      begin : g_five
        a_rsvd_five_bit: assert property (rd_five_s |=> !reg_rd_data_ff[b]) // R16
          else $error("reserved bit set in second capability word");
      end
    end
  endgenerate

  a_vm_ctx_count: assert property (rd_four_s |=> reg_rd_data_ff[31:28] == 4'h1) // R1
    else $error("virtual context comparator count wrong");
  a_ctx_count: assert property (rd_four_s |=> reg_rd_data_ff[27:24] == 4'h1) // R2
    else $error("context comparator count wrong");
  a_sshot_count: assert property (rd_four_s |=> reg_rd_data_ff[23:20] == 4'h1) // R3
    else $error("single-shot control count wrong");
  a_rsel_pairs: assert property (rd_four_s |=> reg_rd_data_ff[19:16] == 4'h7) // R4
    else $error("resource selector pair code wrong");
  a_pe_cmp_none: assert property (rd_four_s |=> reg_rd_data_ff[15:12] == 4'h0) // R5
    else $error("pe comparator inputs not zero");
  a_daddr_none: assert property (rd_four_s |=> !reg_rd_data_ff[8]) // R6
    else $error("data address compare bit set");
  a_dval_none: assert property (rd_four_s |=> reg_rd_data_ff[7:4] == 4'h0) // R7
    else $error("data value comparator count not zero");
  a_addr_pairs: assert property (rd_four_s |=> reg_rd_data_ff[3:0] == 4'h4 && reg_rd_hit_ff) // R8
    else $error("address comparator pair code wrong");
  a_counter_count: assert property (rd_five_s |=> reg_rd_data_ff[30:28] == 3'h2) // R9
    else $error("counter count wrong");
  a_seq_states: assert property (rd_five_s |=> reg_rd_data_ff[27:25] == 3'h4) // R10
    else $error("sequencer state count wrong");
  a_lp_override: assert property (rd_five_s |=> !reg_rd_data_ff[23]) // R11
    else $error("low-power override bit set");
  a_bus_trigger: assert property (rd_five_s |=> reg_rd_data_ff[22]) // R12
    else $error("trace bus trigger bit clear");
  a_id_width: assert property (rd_five_s |=> reg_rd_data_ff[21:16] == 6'h07) // R13
    else $error("trace id width wrong");
  a_ext_sel: assert property (rd_five_s |=> reg_rd_data_ff[11:9] == 3'h4) // R14
    else $error("external input selector count wrong");
  a_ext_inputs: assert property (rd_five_s |=> reg_rd_data_ff[8:0] == 9'h1FF) // R15
    else $error("external input field not all ones");
  a_rsvd_zero: assert property ((rd_four_s |=> reg_rd_data_ff[11:9] == 3'h0)
    and (rd_five_s |=> reg_rd_data_ff[31] == 1'b0 && reg_rd_data_ff[24] == 1'b0
    && reg_rd_data_ff[15:12] == 4'h0)) // R16
    else $error("reserved bits not zero");
  a_wr_no_effect: assert property (reg_wr_en ##1 rd_four_s |=> reg_rd_data_ff == 32'h1117_0004) // R16
    else $error("write altered first capability word");
  a_idle_zero: assert property (!reg_rd_en |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff) // R16
    else $error("read data not zero outside answer cycle");

  // single- and multi-step sequences for unmapped, write-only, back-to-back and mixed traffic
  sequence rd_miss_s;
    reg_rd_en && !sel_four && !sel_five;
  endsequence

  sequence wr_only_s;
    reg_wr_en && !reg_rd_en;
  endsequence

  sequence rd_four_five_s;
    rd_four_s ##1 rd_five_s;
  endsequence

  sequence rd_five_four_s;
    rd_five_s ##1 rd_four_s;
  endsequence

  sequence rd_four_gap_s;
    rd_four_s ##1 !reg_rd_en;
  endsequence

  sequence rd_five_gap_s;
    rd_five_s ##1 !reg_rd_en;
  endsequence

  sequence rd_four_miss_s;
    rd_four_s ##1 rd_miss_s;
  endsequence

  property p_four_whole;
    rd_four_s |=> reg_rd_data_ff == 32'h1117_0004;
  endproperty

  a_four_whole: assert property (p_four_whole) // R16
    else $error("first capability word wrong");

  property p_five_whole;
    rd_five_s |=> reg_rd_data_ff == 32'h2847_09FF;
  endproperty

  a_five_whole: assert property (p_five_whole) // R16
    else $error("second capability word wrong");

  property p_four_hit;
    rd_four_s |=> reg_rd_hit_ff;
  endproperty

  a_four_hit: assert property (p_four_hit) // R16
    else $error("hit flag missing on first word read");

  property p_five_hit;
    rd_five_s |=> reg_rd_hit_ff;
  endproperty

  a_five_hit: assert property (p_five_hit) // R16
    else $error("hit flag missing on second word read");

  property p_miss_zero;
    rd_miss_s |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff;
  endproperty

  a_miss_zero: assert property (p_miss_zero) // R16
    else $error("unmapped read not answered with zero");

  property p_wr_silent;
    wr_only_s |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff;
  endproperty

  a_wr_silent: assert property (p_wr_silent) // R16
    else $error("write produced a read answer");

  property p_wr_five_kept;
    reg_wr_en ##1 rd_five_s |=> reg_rd_data_ff == 32'h2847_09FF;
  endproperty

  a_wr_five_kept: assert property (p_wr_five_kept) // R16
    else $error("write altered second capability word");

  property p_hit_needs_read;
    reg_rd_hit_ff |-> $past(reg_rd_en);
  endproperty

  a_hit_needs_read: assert property (p_hit_needs_read) // R16
    else $error("hit flag without a read");

  property p_data_needs_read;
    reg_rd_data_ff != 32'h0 |-> $past(reg_rd_en);
  endproperty

  a_data_needs_read: assert property (p_data_needs_read) // R16
    else $error("read data without a read");

  property p_four_then_five;
    rd_four_five_s |=> reg_rd_data_ff == 32'h2847_09FF && reg_rd_hit_ff;
  endproperty

  a_four_then_five: assert property (p_four_then_five) // R16
    else $error("back-to-back second word read wrong");

  property p_five_then_four;
    rd_five_four_s |=> reg_rd_data_ff == 32'h1117_0004 && reg_rd_hit_ff;
  endproperty

  a_five_then_four: assert property (p_five_then_four) // R16
    else $error("back-to-back first word read wrong");

  property p_four_gap;
    rd_four_gap_s |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff;
  endproperty

  a_four_gap: assert property (p_four_gap) // R16
    else $error("first word answer stood too long");

  property p_five_gap;
    rd_five_gap_s |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff;
  endproperty

  a_five_gap: assert property (p_five_gap) // R16
    else $error("second word answer stood too long");

  property p_four_miss;
    rd_four_miss_s |=> reg_rd_data_ff == 32'h0 && !reg_rd_hit_ff;
  endproperty

  a_four_miss: assert property (p_four_miss) // R16
    else $error("stale word shown on unmapped read");

  property p_hit_means_map;
    reg_rd_hit_ff |-> $past(sel_four || sel_five);
  endproperty

  a_hit_means_map: assert property (p_hit_means_map) // R16
    else $error("hit flag for unmapped address");

  property p_wr_four_hit;
    reg_wr_en ##1 rd_four_s |=> reg_rd_hit_ff;
  endproperty

  a_wr_four_hit: assert property (p_wr_four_hit) // R16
    else $error("hit flag lost after write");

  property p_rsvd_four_word;
    rd_four_s |=> (reg_rd_data_ff & 32'h0000_0E00) == 32'h0;
  endproperty

  a_rsvd_four_word: assert property (p_rsvd_four_word) // R16
    else $error("first word reserved field not zero");

  property p_rsvd_five_word;
    rd_five_s |=> (reg_rd_data_ff & 32'h8100_F000) == 32'h0;
  endproperty

  a_rsvd_five_word: assert property (p_rsvd_five_word) // R16
    else $error("second word reserved fields not zero");

endmodule

// ===== verif/tcid_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, got, exp); end end
module tb;
  // expected words assembled field by field
  localparam logic [31:0] W4 = {4'h1, 4'h1, 4'h1, 4'h7, 4'h0, 3'h0, 1'h0, 4'h0, 4'h4};
  localparam logic [31:0] W5 = {1'h0, 3'h2, 3'h4, 1'h0, 1'h0, 1'h1, 6'h07, 4'h0, 3'h4, 9'h1FF};
  localparam logic [11:0] A4 = 12'h1F0;
  localparam logic [11:0] A5 = 12'h1F4;
  logic [11:0] bad [5] = '{12'h1EC, 12'h1F8, 12'h1F2, 12'hFF4, 12'h000};
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wr_data = 32'h0000_0000;
  logic reg_wr_en = 1'h0;
  logic reg_rd_en = 1'h0;
  logic [31:0] reg_rd_data_ff;
  logic reg_rd_hit_ff;
  logic [31:0] pe = 32'h0000_0000;
  logic ph = 1'h0;
  int n_fail = 0;
  int check_count = 0;

  tcid_regs u_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_rd_data_ff(reg_rd_data_ff),
    .reg_rd_hit_ff(reg_rd_hit_ff)
  );

  initial forever #2 clock = ~clock;

  // one bus cycle; checks the answer of the previous cycle, so idle cycles must read zero
  task op(input logic w, input logic r, input logic [11:0] a, input logic [31:0] e, input logic h);
    reg_wr_en <= w;
    reg_rd_en <= r;
    reg_addr <= a;
    reg_wr_data <= 32'hFFFF_FFFF;
    @(posedge clock);
    `CHK(reg_rd_data_ff, pe)
    `CHK(reg_rd_hit_ff, ph)
    pe = e;
    ph = h;
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // no open-ended waits, but cut any hang short
  initial
  begin
    #100000;
    n_fail++;
    test_done;
  end

  initial
  begin
    repeat (3) @(posedge clock);
    `CHK(reg_rd_data_ff, 32'h0000_0000)
    sys_rst <= 1'h0;
    op(1'h0, 1'h1, A4, W4, 1'h1);
    op(1'h0, 1'h1, A5, W5, 1'h1);
    op(1'h0, 1'h1, A4, W4, 1'h1);
    op(1'h0, 1'h0, A5, 32'h0000_0000, 1'h0);
    op(1'h0, 1'h0, A5, 32'h0000_0000, 1'h0);
    $display("test reads done");
    foreach (bad[i])
    begin
      op(1'h0, 1'h1, bad[i], 32'h0000_0000, 1'h0);
      op(1'h0, 1'h1, A5, W5, 1'h1);
    end
    op(1'h0, 1'h1, A4, W4, 1'h1);
    op(1'h0, 1'h1, 12'h1EC, 32'h0000_0000, 1'h0);
    $display("test unmapped done");
    // writes of all ones must leave both words untouched
    op(1'h1, 1'h0, A4, 32'h0000_0000, 1'h0);
    op(1'h0, 1'h1, A4, W4, 1'h1);
    op(1'h1, 1'h0, A5, 32'h0000_0000, 1'h0);
    op(1'h0, 1'h1, A5, W5, 1'h1);
    op(1'h1, 1'h0, A5, 32'h0000_0000, 1'h0);
    op(1'h0, 1'h0, 12'h000, 32'h0000_0000, 1'h0);
    $display("test writes done");
    test_done;
  end
endmodule
